// File: rtl/cfo_config_regs.sv
// Converter config bank: two-wire slave, settings, command register
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defines.svh"

// Summary of operation
// RQ1: Write: S, addr+W, register, data, P; all acked.
// RQ2: Read: S, addr+W, register, Sr, addr+R, byte, NACK, P.
// RQ3: Live byte from nonvolatile if select 0, volatile if 1.
// RQ4: Shutdown clears the three select bits.
// RQ5: Command is zero at power-up, shutdown, lockout.
// RQ6: Volatile bytes never reset; load before selecting.
// RQ7: Blank nonvolatile is zero; order 00 keeps outputs off.
// RQ8: Select change updates live settings at once.
// RQ9: Reads of bytes 0-2 follow their select bits.
// RQ10: Programming copies volatile to selected nonvolatile bytes.
// RQ11: Bus writes to 0-2 land in volatile bytes.
// RQ12: Kill bit stops both stages; clearing restarts soft-start.
// RQ13: Bit 5 resets bus logic and command register.
// RQ14: Bit 6 reads fault; write one or reset clears it.
// RQ15: Fault on low programming supply or locked programming.
// RQ16: Bit 7 starts programming; master clears it to finish.
// RQ17: Selects at 2:0; reserved bit 3 reads zero.
// RQ18: Byte 2: lock, fine, ramp 2^field uA, discharge, order.
// RQ19: Order 00 off, 01 negative first, 10 positive first, 11 both.
// RQ20: Discharge enable only with order 11; code passes the discharge bit through for any order.
// RQ21: Positive: 3.2 V + code*50 mV + fine*25 mV, codes 0-191.
// RQ22: Negative: -1.2 V - code*50 mV, codes 0-255.
// RQ23: Ramps start after 64 us start-up delay.
// RQ24: Bus ignored in shutdown and 64 us after.
// RQ25: Locked part refuses programming and faults; lock reads true.
// RQ26: Unmapped: writes acked and dropped, reads zero.
// RQ27: One data byte per write; later bytes not acked.

module cfo_config_regs #(
   parameter int STARTUP_CYCLES = `CFO_T_STARTUP_US * `CFO_CLK_MHZ
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Pins from outside the clock domain
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic shutdown_input_n_in,
   input wire logic lockout_in,
   input wire logic address_select_pin_in,
   input wire logic vpp_ok_in,
   input wire logic pos_regulated_in,
   input wire logic neg_regulated_in,
   // Open-drain data line
   output logic sda_out,
   output logic sda_oe_n_out,
   // Live settings
   output logic [7:0] positive_level_code_out,
   output logic [7:0] negative_level_code_out,
   output logic positive_fine_step_out,
   output logic [1:0] ramp_current_field_out,
   output logic [3:0] ramp_current_ua_out,
   output logic discharge_enable_out,
   output logic [1:0] power_order_field_out,
   output logic otp_lock_out,
   output logic [13:0] positive_target_mv_out,
   output logic [13:0] negative_target_mv_out,
   // Power stage control
   output logic power_stage_kill_out,
   output logic pos_ramp_go_out,
   output logic neg_ramp_go_out,
   output logic bus_ready_out
);

   localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);

   cfo_otp_if otp ();

   logic [7:0] async_bus;
   logic [7:0] meta_ff;
   logic [7:0] sync_ff;
   logic scl_s, sda_s, shutdown_input_n_s, lockout_s, ca_s, vpp_s, pos_reg_s, neg_reg_s;
   logic scl_q_ff, sda_q_ff;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [15:0] start_cnt_ff;
   logic ready_ff;
   cfo_pkg::cfo_state_t state_ff, nxt_state;
   logic [3:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic in_ack_ff, nxt_in_ack;
   logic drive_ff, nxt_drive;
   logic [7:0] reg_addr_ff, nxt_reg_addr;
   logic wr_commit;
   logic [6:0] dev_addr;
   logic cmd_wr, rst_cmd, cmd_clr;
   logic cmd_prog_ff, cmd_kill_ff, fault_ff;
   logic [2:0] sel_ff;
   logic [7:0] cmd_read, rd_data, seq_read;
   logic [7:0] vol_ff [3];
   logic [7:0] live_ff [3];
   logic [7:0] live_byte [3];
   logic nv_lock, run;
   logic pos_go_ff, neg_go_ff;
   logic [7:0] pos_code_clamp;
   logic [13:0] pos_mv_ff, neg_mv_ff;

   // Pins pass two flops first
   assign async_bus = {neg_regulated_in, pos_regulated_in, vpp_ok_in, address_select_pin_in,
                       lockout_in, shutdown_input_n_in, sda_in, scl_in};
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         meta_ff <= `CFO_SYNC_RESET;
         sync_ff <= `CFO_SYNC_RESET;
      end else begin
         meta_ff <= async_bus;
         sync_ff <= meta_ff;
      end
   end

   assign {neg_reg_s, pos_reg_s, vpp_s, ca_s, lockout_s, shutdown_input_n_s, sda_s, scl_s} = sync_ff;

   // Previous line levels for edge detection
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
      end
   end

   // START/STOP only with clock line high
   assign scl_rise = scl_s & ~scl_q_ff;
   assign scl_fall = ~scl_s & scl_q_ff;
   assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
   assign dev_addr = ca_s ? `CFO_DEV_ADDR_CA1 : `CFO_DEV_ADDR_CA0;

   // Start-up delay after the shutdown input rises
   // RQ24 bus held off
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !shutdown_input_n_s) begin
         start_cnt_ff <= 16'h0000;
         ready_ff <= 1'b0;
      end else if (!ready_ff) begin
         if (start_cnt_ff == STARTUP_LAST) begin
            ready_ff <= 1'b1;
         end else begin
            start_cnt_ff <= start_cnt_ff + 16'h0001;
         end
      end
   end

   // Slave: sample on SCL rise, drive on fall
   always_comb begin
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift = shift_ff;
      nxt_in_ack = in_ack_ff;
      nxt_drive = drive_ff;
      nxt_reg_addr = reg_addr_ff;
      wr_commit = 1'b0;
      if (!ready_ff) begin
         nxt_state = cfo_pkg::ST_IDLE;
         nxt_bit_cnt = 4'h0;
         nxt_in_ack = 1'b0;
         nxt_drive = 1'b0;
      end else if (start_det) begin
         // RQ2 repeated start accepted
         nxt_state = cfo_pkg::ST_ADDR;
         nxt_bit_cnt = 4'h0;
         nxt_in_ack = 1'b0;
         nxt_drive = 1'b0;
      end else if (stop_det) begin
         nxt_state = cfo_pkg::ST_IDLE;
         nxt_bit_cnt = 4'h0;
         nxt_in_ack = 1'b0;
         nxt_drive = 1'b0;
      end else if (state_ff == cfo_pkg::ST_IDLE || state_ff == cfo_pkg::ST_IGNORE) begin
         nxt_drive = 1'b0;
      end else if (scl_rise) begin
         if (bit_cnt_ff < 4'h8) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (state_ff != cfo_pkg::ST_READ) begin
               nxt_shift = {shift_ff[6:0], sda_s};
            end
         end
      end else if (scl_fall) begin
         if (in_ack_ff) begin
            // Ack clock over: release, act on byte
            nxt_in_ack = 1'b0;
            nxt_drive = 1'b0;
            nxt_bit_cnt = 4'h0;
            case (state_ff)
               cfo_pkg::ST_ADDR: begin
                  if (shift_ff[0]) begin
                     nxt_state = cfo_pkg::ST_READ;
                     nxt_shift = rd_data;
                     nxt_drive = ~rd_data[7];
                  end else begin
                     nxt_state = cfo_pkg::ST_REG;
                  end
               end
               cfo_pkg::ST_REG: nxt_state = cfo_pkg::ST_DATA;
               cfo_pkg::ST_DATA: begin
                  // RQ1 data byte stored
                  wr_commit = 1'b1;
                  nxt_state = cfo_pkg::ST_EXTRA;
               end
               default: nxt_state = state_ff;
            endcase
         end else if (bit_cnt_ff == 4'h8) begin
            case (state_ff)
               cfo_pkg::ST_ADDR: begin
                  if (shift_ff[7:1] == dev_addr) begin
                     nxt_in_ack = 1'b1;
                     nxt_drive = 1'b1;
                  end else begin
                     nxt_state = cfo_pkg::ST_IGNORE;
                  end
               end
               cfo_pkg::ST_REG: begin
                  // RQ1 register byte acked
                  nxt_reg_addr = shift_ff;
                  nxt_in_ack = 1'b1;
                  nxt_drive = 1'b1;
               end
               cfo_pkg::ST_DATA: begin
                  nxt_in_ack = 1'b1;
                  nxt_drive = 1'b1;
               end
               cfo_pkg::ST_EXTRA: begin
                  // RQ27 extra bytes not acked
                  nxt_in_ack = 1'b1;
                  nxt_drive = 1'b0;
               end
               default: begin
                  // RQ2 one byte per read
                  nxt_drive = 1'b0;
                  nxt_state = cfo_pkg::ST_IGNORE;
               end
            endcase
         end else if (state_ff == cfo_pkg::ST_READ) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_drive = ~shift_ff[6];
         end
      end
   end

   // Slave state; command reset bit lands here too
   // RQ13 bus logic reset
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || rst_cmd) begin
         state_ff <= cfo_pkg::ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         in_ack_ff <= 1'b0;
         drive_ff <= 1'b0;
         reg_addr_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= nxt_shift;
         in_ack_ff <= nxt_in_ack;
         drive_ff <= nxt_drive;
         reg_addr_ff <= nxt_reg_addr;
      end
   end

   // Open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe_n_out = ~drive_ff;

   // Command decode
   assign cmd_wr = wr_commit && (reg_addr_ff == `CFO_ADDR_CMD);
   assign rst_cmd = cmd_wr && shift_ff[`CFO_CMD_RST];
   // RQ5 zero in shutdown and lockout
   assign cmd_clr = ~shutdown_input_n_s | lockout_s | rst_cmd;

   // Command register; reserved bit 3 is never stored
   // RQ4 selects cleared in shutdown
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || cmd_clr) begin
         cmd_prog_ff <= 1'b0;
         cmd_kill_ff <= 1'b0;
         sel_ff <= 3'h0;
      end else if (cmd_wr) begin
         cmd_prog_ff <= shift_ff[`CFO_CMD_PROG];
         cmd_kill_ff <= shift_ff[`CFO_CMD_KILL];
         sel_ff <= shift_ff[2:0];
      end
   end

   // A new fault beats a clear in the same cycle
   // RQ14 fault read and clear
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         fault_ff <= 1'b0;
      end else if (otp.fault_set) begin
         fault_ff <= 1'b1;
      end else if (cmd_clr || (cmd_wr && shift_ff[`CFO_CMD_FAULT])) begin
         fault_ff <= 1'b0;
      end
   end

   // Programming handshake with the store
   // RQ16 rising program bit
   assign otp.prog_start = cmd_wr & shift_ff[`CFO_CMD_PROG] & ~cmd_prog_ff & ~rst_cmd;
   assign otp.prog_active = cmd_prog_ff;
   assign otp.sel = sel_ff;
   assign otp.vpp_ok = vpp_s;
   assign nv_lock = otp.nv_data[2][`CFO_SEQ_LOCK];

   // Per setting byte: volatile store, source select, live copy
   for (genvar g = 0; g < 3; g++) begin : g_setting
      // RQ6 never reset
      // RQ11 writes hit volatile only
      always_ff @(posedge clk_in) begin
         if (wr_commit && reg_addr_ff == 8'(g)) begin
            vol_ff[g] <= shift_ff;
         end
      end
      assign otp.vol_data[g] = vol_ff[g];
      // RQ3 source per select bit
      assign live_byte[g] = sel_ff[g] ? vol_ff[g] : otp.nv_data[g];
      // RQ8 next cycle update
      always_ff @(posedge clk_in) begin
         if (!reset_n_in) begin
            live_ff[g] <= 8'h00;
         end else begin
            live_ff[g] <= live_byte[g];
         end
      end
   end

   // Read mux; lock bit always shows the stored lock
   // RQ17 reserved bit reads zero
   assign cmd_read = {cmd_prog_ff, fault_ff, 1'b0, cmd_kill_ff, 1'b0, sel_ff};
   // RQ25 true lock readback
   assign seq_read = {live_byte[2][7], nv_lock, live_byte[2][5:0]};
   // RQ9 reads follow select
   // RQ26 unmapped reads zero
   assign rd_data = (reg_addr_ff == `CFO_ADDR_POS) ? live_byte[0] :
                    (reg_addr_ff == `CFO_ADDR_NEG) ? live_byte[1] :
                    (reg_addr_ff == `CFO_ADDR_SEQ) ? seq_read :
                    (reg_addr_ff == `CFO_ADDR_CMD) ? cmd_read : 8'h00;

   // Ramp order; second output waits for first to regulate
   // RQ23 ramps after start-up
   assign run = ready_ff & ~cmd_kill_ff & ~lockout_s;
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !run) begin
         pos_go_ff <= 1'b0;
         neg_go_ff <= 1'b0;
      end else begin
         // RQ19 order decode
         case (cfo_pkg::cfo_order_t'(live_ff[2][`CFO_SEQ_ORDER_HI:0]))
            cfo_pkg::ORD_BOTH: begin
               pos_go_ff <= 1'b1;
               neg_go_ff <= 1'b1;
            end
            cfo_pkg::ORD_NEG_FIRST: begin
               neg_go_ff <= 1'b1;
               pos_go_ff <= pos_go_ff | neg_reg_s;
            end
            cfo_pkg::ORD_POS_FIRST: begin
               pos_go_ff <= 1'b1;
               neg_go_ff <= neg_go_ff | pos_reg_s;
            end
            default: begin
               // RQ7 zero order keeps off
               pos_go_ff <= 1'b0;
               neg_go_ff <= 1'b0;
            end
         endcase
      end
   end

   // Targets; codes above range clamp to top code
   assign pos_code_clamp = (live_ff[0] > `CFO_POS_CODE_MAX) ? `CFO_POS_CODE_MAX : live_ff[0];
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         pos_mv_ff <= `CFO_POS_BASE_MV;
         neg_mv_ff <= `CFO_NEG_BASE_MV;
      end else begin
         // RQ21 positive target
         pos_mv_ff <= 14'(`CFO_POS_BASE_MV + 14'(pos_code_clamp) * `CFO_STEP_MV
                          + (live_ff[2][`CFO_SEQ_FINE] ? `CFO_FINE_MV : 14'h000));
         // RQ22 negative magnitude
         neg_mv_ff <= 14'(`CFO_NEG_BASE_MV + 14'(live_ff[1]) * `CFO_STEP_MV);
      end
   end

   // Settings out; discharge passed through as set
   // RQ18 field layout
   assign positive_level_code_out = live_ff[0];
   assign negative_level_code_out = live_ff[1];
   assign positive_fine_step_out = live_ff[2][`CFO_SEQ_FINE];
   assign ramp_current_field_out = live_ff[2][`CFO_SEQ_RAMP_HI:`CFO_SEQ_RAMP_LO];
   assign ramp_current_ua_out = 4'h1 << live_ff[2][`CFO_SEQ_RAMP_HI:`CFO_SEQ_RAMP_LO];
   assign discharge_enable_out = live_ff[2][`CFO_SEQ_DIS];
   assign power_order_field_out = live_ff[2][`CFO_SEQ_ORDER_HI:0];
   assign otp_lock_out = nv_lock;
   assign positive_target_mv_out = pos_mv_ff;
   assign negative_target_mv_out = neg_mv_ff;

   // Kill drives the power stage kill output directly
   // RQ12 stages off immediately
   assign power_stage_kill_out = cmd_kill_ff;
   assign pos_ramp_go_out = pos_go_ff;
   assign neg_ramp_go_out = neg_go_ff;
   assign bus_ready_out = ready_ff;

   cfo_otp_store u_otp_store (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .otp(otp.store)
   );

endmodule

`default_nettype wire

// File: rtl/cfo_defines.svh
// Offsets, field positions, reset values and timing counts of the config bank
`ifndef CFO_DEFINES_SVH
`define CFO_DEFINES_SVH

// Register addresses
`define CFO_ADDR_POS 8'h00
`define CFO_ADDR_NEG 8'h01
`define CFO_ADDR_SEQ 8'h02
`define CFO_ADDR_CMD 8'h04

// Bus slave addresses, chosen by the address select pin
`define CFO_DEV_ADDR_CA1 7'h31
`define CFO_DEV_ADDR_CA0 7'h45

// Command register fields
`define CFO_CMD_PROG 7
`define CFO_CMD_FAULT 6
`define CFO_CMD_RST 5
`define CFO_CMD_KILL 4
`define CFO_CMD_RESET 8'h00

// Sequence/ramp byte fields
`define CFO_SEQ_LOCK 6
`define CFO_SEQ_FINE 5
`define CFO_SEQ_RAMP_HI 4
`define CFO_SEQ_RAMP_LO 3
`define CFO_SEQ_DIS 2
`define CFO_SEQ_ORDER_HI 1

// Output target arithmetic, millivolts
`define CFO_POS_BASE_MV 14'hc80
`define CFO_NEG_BASE_MV 14'h4b0
`define CFO_STEP_MV 14'h032
`define CFO_FINE_MV 14'h019
`define CFO_POS_CODE_MAX 8'hbf

// Timing
`define CFO_CLK_MHZ 125
`define CFO_T_STARTUP_US 64

// Synchroniser reset: bus lines idle high
`define CFO_SYNC_RESET 8'h03

`endif

// File: rtl/cfo_otp_if.sv
// Link between the register bank and the one-time-programmable store
`timescale 1ns/1ps
`default_nettype none

interface cfo_otp_if;
   logic prog_start;
   logic prog_active;
   logic [2:0] sel;
   logic [2:0][7:0] vol_data;
   logic vpp_ok;
   logic [2:0][7:0] nv_data;
   logic fault_set;

   modport store (
      input prog_start, prog_active, sel, vol_data, vpp_ok,
      output nv_data, fault_set
   );
   modport bank (
      output prog_start, prog_active, sel, vol_data, vpp_ok,
      input nv_data, fault_set
   );
endinterface

`default_nettype wire

// File: rtl/cfo_otp_store.sv
// One-time-programmable shadow bytes with lock and fault detection
`timescale 1ns/1ps
`default_nettype none
`include "cfo_defines.svh"

module cfo_otp_store (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Bank side
   cfo_otp_if.store otp
);

   // Blank parts read all zeros; contents survive reset
   logic [7:0] nv_mem [3] = '{default: 8'h00};
   logic fault_set_ff;
   logic nv_lock;
   logic prog_ok;

   assign nv_lock = nv_mem[2][`CFO_SEQ_LOCK];
   // RQ25 lock blocks programming
   assign prog_ok = otp.prog_start & ~nv_lock & otp.vpp_ok;

   // Per byte: only selected bytes take their volatile copy
   for (genvar g = 0; g < 3; g++) begin : g_byte
      // RQ10 selected bytes programmed
      always_ff @(posedge clk_in) begin
         if (prog_ok && otp.sel[g]) begin
            nv_mem[g] <= otp.vol_data[g];
         end
      end
      assign otp.nv_data[g] = nv_mem[g];
   end

   // RQ15 fault on lock or low supply
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         fault_set_ff <= 1'b0;
      end else begin
         fault_set_ff <= (otp.prog_start & nv_lock) | (otp.prog_active & ~otp.vpp_ok);
      end
   end

   assign otp.fault_set = fault_set_ff;

endmodule

`default_nettype wire

// File: rtl/cfo_pkg.sv
// Types shared by the config bank modules
package cfo_pkg;

   // Bus slave transaction phase
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_REG    = 3'b010,
      ST_DATA   = 3'b011,
      ST_EXTRA  = 3'b100,
      ST_READ   = 3'b101,
      ST_IGNORE = 3'b110
   } cfo_state_t;

   // Power-up order codes
   typedef enum logic [1:0] {
      ORD_OFF       = 2'b00,
      ORD_NEG_FIRST = 2'b01,
      ORD_POS_FIRST = 2'b10,
      ORD_BOTH      = 2'b11
   } cfo_order_t;

endpackage

// File: verification/cfo_config_regs_monitor.sv
// Concurrent checks on the config bank pins
`timescale 1ns/1ps
`default_nettype none
module cfo_config_regs_monitor (
   // Clock, reset and inputs
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic shutdown_input_n_in,
   // Watched outputs
   input wire logic sda_oe_n_out,
   input wire logic [7:0] positive_level_code_out,
   input wire logic [7:0] negative_level_code_out,
   input wire logic positive_fine_step_out,
   input wire logic [1:0] ramp_current_field_out,
   input wire logic [3:0] ramp_current_ua_out,
   input wire logic [1:0] power_order_field_out,
   input wire logic [13:0] positive_target_mv_out,
   input wire logic [13:0] negative_target_mv_out,
   input wire logic power_stage_kill_out,
   input wire logic pos_ramp_go_out,
   input wire logic neg_ramp_go_out,
   input wire logic bus_ready_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Expected targets, positive code clamped
   wire logic [7:0] pos_code = (positive_level_code_out > 8'hbf) ? 8'hbf : positive_level_code_out;
   wire logic [13:0] pos_exp = 14'hc80 + 14'h032 * {6'h0, pos_code}
      + {13'h0, positive_fine_step_out} * 14'h019;
   wire logic [13:0] neg_exp = 14'h4b0 + 14'h032 * {6'h0, negative_level_code_out};

   property p_sda_hold; (sda_oe_n_out != $past(sda_oe_n_out)) |-> !scl_in && !$past(scl_in); endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("sda moved with scl high");
   property p_kill_sd; (!shutdown_input_n_in) [*6] |-> !power_stage_kill_out; endproperty
   a_kill_sd: assert property (p_kill_sd) else $error("kill set in shutdown");
   property p_ready_sd; (!shutdown_input_n_in) [*6] |-> !bus_ready_out; endproperty
   a_ready_sd: assert property (p_ready_sd) else $error("bus ready in shutdown");
   property p_kill_go; power_stage_kill_out |=> !pos_ramp_go_out && !neg_ramp_go_out; endproperty
   a_kill_go: assert property (p_kill_go) else $error("ramp on while killed");
   property p_order_off;
      (power_order_field_out == 2'b00) [*3] |-> !pos_ramp_go_out && !neg_ramp_go_out;
   endproperty
   a_order_off: assert property (p_order_off) else $error("ramp on with order off");
   property p_ramp_ua;
      $stable(ramp_current_field_out) |-> ramp_current_ua_out == (4'h1 << ramp_current_field_out);
   endproperty
   a_ramp_ua: assert property (p_ramp_ua) else $error("ramp current wrong");
   property p_pos_mv;
      ($stable(positive_level_code_out) && $stable(positive_fine_step_out)) [*3]
         |-> positive_target_mv_out == pos_exp;
   endproperty
   a_pos_mv: assert property (p_pos_mv) else $error("positive target wrong");
   property p_neg_mv; $stable(negative_level_code_out) [*3] |-> negative_target_mv_out == neg_exp; endproperty
   a_neg_mv: assert property (p_neg_mv) else $error("negative target wrong");
endmodule
bind cfo_config_regs cfo_config_regs_monitor i_cfo_config_regs_monitor (.*);
`default_nettype wire

// File: verification/cfo_i2c_master.sv
// Two-wire bus master model for the config bank
`timescale 1ns/1ps
`default_nettype none
module cfo_i2c_master (
   // Clock and resolved data wire
   input wire logic clk_in,
   input wire logic sda_in,
   // Master drives, one means released
   output logic scl_out,
   output logic sda_out
);
   logic r;
   // Bus idles high, clock stands still between frames
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Half periods of 10 clocks high, 12 clocks low
   task automatic hp(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic start();
      sda_out <= 1'b1;
      hp(10);
      scl_out <= 1'b1;
      hp(10);
      sda_out <= 1'b0;
      hp(10);
      scl_out <= 1'b0;
      hp(2);
   endtask
   // Data moves only while scl is low
   task automatic bit_io(input logic b, output logic q);
      sda_out <= b;
      hp(10);
      scl_out <= 1'b1;
      hp(10);
      q = sda_in;
      scl_out <= 1'b0;
      hp(2);
   endtask
   task automatic tx(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rx(output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
   endtask
   task automatic stop();
      sda_out <= 1'b0;
      hp(10);
      scl_out <= 1'b1;
      hp(10);
      sda_out <= 1'b1;
      hp(10);
   endtask
endmodule
`default_nettype wire

// File: verification/tb_cfo_config_regs.sv
// Self-checking bench for the config bank
`timescale 1ns/1ps
`default_nettype none
module tb_cfo_config_regs;
   logic clk_in, reset_n_in, sda_m, shutdown_input_n, lockout, ca, vpp_ok, regulated, ack_exp;
   wire logic scl, sda_w, sda_oe_n, fine, dis, lock, kill, ready;
   wire logic [7:0] pcode, ncode;
   wire logic [1:0] ramp, order, gos;
   logic [7:0] v [3];
   logic [6:0] dev;
   integer seed, miscompares, checks_done;
   // Open-drain wire with pull-up
   assign sda_w = sda_oe_n ? sda_m : 1'b0;
   cfo_i2c_master i_cfo_i2c_master (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));
   cfo_config_regs #(.STARTUP_CYCLES(20)) i_cfo_config_regs (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_w), .shutdown_input_n_in(shutdown_input_n),
      .lockout_in(lockout), .address_select_pin_in(ca), .vpp_ok_in(vpp_ok),
      .pos_regulated_in(regulated), .neg_regulated_in(regulated), .sda_out(),
      .sda_oe_n_out(sda_oe_n), .positive_level_code_out(pcode), .negative_level_code_out(ncode),
      .positive_fine_step_out(fine), .ramp_current_field_out(ramp), .ramp_current_ua_out(),
      .discharge_enable_out(dis), .power_order_field_out(order), .otp_lock_out(lock),
      .positive_target_mv_out(), .negative_target_mv_out(), .power_stage_kill_out(kill),
      .pos_ramp_go_out(gos[1]), .neg_ramp_go_out(gos[0]), .bus_ready_out(ready));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      if (got !== exp)
         miscompares++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic x = 1'b0);
      logic k0, k1, k2, kx;
      kx = 1'b0;
      i_cfo_i2c_master.start();
      i_cfo_i2c_master.tx({dev, 1'b0}, k0);
      i_cfo_i2c_master.tx(a, k1);
      i_cfo_i2c_master.tx(d, k2);
      if (x)
         i_cfo_i2c_master.tx(8'hff, kx);
      i_cfo_i2c_master.stop();
      chk({14'h0, k0 & k1 & k2, kx}, {14'h0, ack_exp, 1'b0});
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic k;
      logic [7:0] d;
      i_cfo_i2c_master.start();
      i_cfo_i2c_master.tx({dev, 1'b0}, k);
      i_cfo_i2c_master.tx(a, k);
      i_cfo_i2c_master.start();
      i_cfo_i2c_master.tx({dev, 1'b1}, k);
      i_cfo_i2c_master.rx(d);
      i_cfo_i2c_master.stop();
      chk({8'h0, d}, {8'h0, e});
   endtask
   task automatic prog(input logic [2:0] s);
      wr(8'h04, {5'h02, s});
      wr(8'h04, {5'h12, s});
      wr(8'h04, {5'h02, s});
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      chk({15'h0, n >= 20 && n < 300}, 16'h1);
   endtask
   // Ramp enables {pos, neg} for an order code
   function automatic logic [1:0] go_exp(input logic [1:0] o, input logic done);
      go_exp = (o == 2'b00) ? 2'b00 : (done ? 2'b11 : o);
   endfunction
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog, roughly twice the expected run
   initial begin
      #700000;
      miscompares++;
      give_verdict();
   end
   initial begin
      seed = 32'h15f9;
      miscompares = 0;
      checks_done = 0;
      {reset_n_in, shutdown_input_n, lockout, ca, vpp_ok, regulated, ack_exp} = 7'h2f;
      dev = 7'h31;
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      wait_ready();
      chk({14'h0, order}, 16'h0);
      rd(8'h00, 8'h00);
      foreach (v[i]) v[i] = $random(seed);
      // load volatile bytes first; lock, discharge clear
      v[2] = v[2] & 8'h3b;
      foreach (v[i]) wr(i[7:0], v[i]);
      rd(8'h00, 8'h00);
      wr(8'h04, 8'h1f);
      chk({pcode, ncode}, {v[0], v[1]});
      chk({10'h0, fine, ramp, dis, order}, {10'h0, v[2][5:0]});
      foreach (v[i]) rd(i[7:0], v[i]);
      rd(8'h04, 8'h17);
      wr(8'h03, v[0]);
      rd(8'h03, 8'h00);
      rd(8'h80 | v[1], 8'h00);
      wr(8'h04, 8'h13, 1'b1);
      rd(8'h04, 8'h13);
      prog(3'b001);
      wr(8'h04, 8'h10);
      rd(8'h00, v[0]);
      rd(8'h01, 8'h00);
      rd(8'h04, 8'h10);
      vpp_ok <= 1'b0;
      prog(3'b010);
      rd(8'h04, 8'h52);
      wr(8'h04, 8'h50);
      rd(8'h04, 8'h10);
      vpp_ok <= 1'b1;
      v[2] = v[2] | 8'h40;
      wr(8'h02, v[2]);
      prog(3'b100);
      chk({15'h0, lock}, 16'h1);
      wr(8'h00, ~v[0]);
      prog(3'b001);
      rd(8'h04, 8'h51);
      wr(8'h04, 8'h10);
      rd(8'h00, v[0]);
      wr(8'h04, 8'h20);
      rd(8'h04, 8'h00);
      for (int o = 0; o < 4; o++) begin
         // discharge only with both ramping together
         wr(8'h02, {5'h0, o == 3, o[1:0]});
         wr(8'h04, 8'h14);
         chk({13'h0, kill, gos}, 16'h4);
         regulated <= 1'b0;
         wr(8'h04, 8'h04);
         chk({14'h0, gos}, {14'h0, go_exp(o[1:0], 1'b0)});
         regulated <= 1'b1;
         repeat (8) @(posedge clk_in);
         chk({14'h0, gos}, {14'h0, go_exp(o[1:0], 1'b1)});
      end
      shutdown_input_n <= 1'b0;
      repeat (10) @(posedge clk_in);
      ack_exp = 1'b0;
      wr(8'h04, 8'h17);
      shutdown_input_n <= 1'b1;
      wait_ready();
      ack_exp = 1'b1;
      rd(8'h04, 8'h00);
      chk({14'h0, order}, {14'h0, v[2][1:0]});
      wr(8'h04, 8'h17);
      lockout <= 1'b1;
      repeat (8) @(posedge clk_in);
      lockout <= 1'b0;
      rd(8'h04, 8'h00);
      ca <= 1'b0;
      dev = 7'h31;
      ack_exp = 1'b0;
      wr(8'h04, 8'h17);
      ack_exp = 1'b1;
      dev = 7'h45;
      rd(8'h04, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
